// ### hw/ndc_decoder.sv
// Direct-command decoder with classic Wishbone register slave
//
// What this block does
// - Accept command only when its mode bits are set, or clear where negated
// - Unmask receive: en, rx_en; chainable, no irq
// - Measure amplitude: en; store result, irq
// - Squelch: en, rx_en; reduce gain, no irq
// - Reset gain: load manual gain, no irq
// - Adjust regulators, irq; refused if external regulation
// - Calibrate modulation depth, then irq
// - Calibrate antenna tuning caps, then irq
// - Measure phase, then irq
// - Clear signal strength; chainable, no irq
// - Transparent mode: en; no irq, not chainable
// - Capacitive calibration only when manual bit zero
// - Capacitance measurement in every mode, irq
// - Timer starts chainable; mask timer needs target mode
// - Test access enables test writes; others ignored
// - Set default resets all but opctl, io configs
// - Set default without en keeps FIFO
// - Set default drops calibration results
// - Set default not chainable, no irq
// - Clear stops activity, FIFO, timers; keeps NRT if BIT_NRT_EMV set
// - Clear resets collision and interrupt registers
// - Clear needs en and stable crystal
`timescale 1ns/1ps
module ndc_decoder (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input wire logic xtal_stable_i,
    input wire logic eng_done_i,
    input wire logic [7:0] eng_result_i,
    input wire logic [3:0] noise_gain_i,
    output logic [ndc_pkg::NUM_ACT-1:0] act_o,
    output ndc_pkg::ndc_clear_type clear_o,
    output logic term_irq_o,
    output logic busy_o,
    output logic transparent_o,
    output logic test_wr_en_o,
    output logic [3:0] gain_red_o,
    output logic [7:0] opctl_o,
    output logic [7:0] iocfg1_o,
    output logic [7:0] iocfg2_o
);

    // ----------------------------------------------------------------
    // Command classification
    // ----------------------------------------------------------------
    function automatic ndc_pkg::ndc_info_type info_of(
        input logic [7:0] code
    );
        ndc_pkg::ndc_info_type r;
        r = '{known: 1'b1, chain: 1'b0, term_irq: 1'b0, act: 5'h00};
        unique case (code)
            ndc_pkg::CMD_SET_DEFAULT: r.act = 5'(ndc_pkg::A_SET_DEFAULT);
            ndc_pkg::CMD_CLEAR_A, ndc_pkg::CMD_CLEAR_B: begin
                r.chain = 1'b1;
                r.act = 5'(ndc_pkg::A_CLEAR);
            end
            ndc_pkg::CMD_UNMASK_RX: begin
                r.chain = 1'b1;
                r.act = 5'(ndc_pkg::A_UNMASK_RX);
            end
            ndc_pkg::CMD_MEAS_AMP: begin
                r.term_irq = 1'b1;
                r.act = 5'(ndc_pkg::A_MEAS_AMP);
            end
            ndc_pkg::CMD_SQUELCH: r.act = 5'(ndc_pkg::A_SQUELCH);
            ndc_pkg::CMD_RESET_GAIN: r.act = 5'(ndc_pkg::A_RESET_GAIN);
            ndc_pkg::CMD_ADJ_REG: begin
                r.term_irq = 1'b1;
                r.act = 5'(ndc_pkg::A_ADJ_REG);
            end
            ndc_pkg::CMD_CAL_MOD: begin
                r.term_irq = 1'b1;
                r.act = 5'(ndc_pkg::A_CAL_MOD);
            end
            ndc_pkg::CMD_CAL_ANT: begin
                r.term_irq = 1'b1;
                r.act = 5'(ndc_pkg::A_CAL_ANT);
            end
            ndc_pkg::CMD_MEAS_PHASE: begin
                r.term_irq = 1'b1;
                r.act = 5'(ndc_pkg::A_MEAS_PHASE);
            end
            ndc_pkg::CMD_CLR_SIGSTR: begin
                r.chain = 1'b1;
                r.act = 5'(ndc_pkg::A_CLR_SIGSTR);
            end
            ndc_pkg::CMD_TRANSPARENT: r.act = 5'(ndc_pkg::A_TRANSPARENT);
            ndc_pkg::CMD_CAL_CAP: begin
                r.term_irq = 1'b1;
                r.act = 5'(ndc_pkg::A_CAL_CAP);
            end
            ndc_pkg::CMD_MEAS_CAP: begin
                r.term_irq = 1'b1;
                r.act = 5'(ndc_pkg::A_MEAS_CAP);
            end
            ndc_pkg::CMD_MEAS_SUPPLY: begin
                r.term_irq = 1'b1;
                r.act = 5'(ndc_pkg::A_MEAS_SUPPLY);
            end
            ndc_pkg::CMD_START_GPT: begin
                r.chain = 1'b1;
                r.act = 5'(ndc_pkg::A_START_GPT);
            end
            ndc_pkg::CMD_START_WUT: begin
                r.chain = 1'b1;
                r.act = 5'(ndc_pkg::A_START_WUT);
            end
            ndc_pkg::CMD_START_MRT: begin
                r.chain = 1'b1;
                r.act = 5'(ndc_pkg::A_START_MRT);
            end
            ndc_pkg::CMD_START_NRT: begin
                r.chain = 1'b1;
                r.act = 5'(ndc_pkg::A_START_NRT);
            end
            // Test access has no engine strobe; it only opens test writes
            ndc_pkg::CMD_TEST_ACCESS: r.chain = 1'b1;
            default: r.known = 1'b0;
        endcase
        return r;
    endfunction : info_of

    // Mode check: listed control bits must be set, or clear where negated
    function automatic logic mode_ok(
        input logic [7:0] code,
        input logic [7:0] op,
        input logic [7:0] aux,
        input logic xtal
    );
        logic en;
        logic rx;
        en = op[ndc_pkg::BIT_EN];
        rx = op[ndc_pkg::BIT_RX_EN];
        unique case (code)
            ndc_pkg::CMD_CLEAR_A, ndc_pkg::CMD_CLEAR_B:
                mode_ok = en && xtal;
            ndc_pkg::CMD_UNMASK_RX, ndc_pkg::CMD_SQUELCH,
            ndc_pkg::CMD_START_NRT:
                mode_ok = en && rx;
            ndc_pkg::CMD_ADJ_REG:
                mode_ok = en && !aux[ndc_pkg::BIT_REG_S];
            ndc_pkg::CMD_CAL_CAP:
                mode_ok = !aux[ndc_pkg::BIT_CS_MCAL];
            ndc_pkg::CMD_START_WUT:
                mode_ok = !op[ndc_pkg::BIT_WU];
            ndc_pkg::CMD_START_MRT:
                mode_ok = aux[ndc_pkg::BIT_TGT_INIT];
            ndc_pkg::CMD_SET_DEFAULT, ndc_pkg::CMD_MEAS_CAP,
            ndc_pkg::CMD_TEST_ACCESS:
                mode_ok = 1'b1;
            default:
                mode_ok = en;
        endcase
    endfunction : mode_ok

    // ----------------------------------------------------------------
    // Wishbone slave
    // ----------------------------------------------------------------
    logic ack_q;
    logic bus_req;
    logic wr_lo;
    logic [7:0] opctl_q;
    logic [7:0] iocfg1_q;
    logic [7:0] iocfg2_q;
    logic [7:0] aux_q;
    logic [7:0] last_cmd_q;
    logic [7:0] result_q;
    logic [3:0] gain_q;
    logic transp_q;
    logic test_wr_q;
    logic refused_q;
    ndc_pkg::ndc_state_type state_q;

    // Effects land on the acked edge, so one write is one command
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr_lo = bus_req && wb_we_i && wb_sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else if (ce_i) begin
            ack_q <= bus_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i && bus_req) begin
            unique case (wb_adr_i)
                ndc_pkg::OFS_OPCTL: wb_dat_o <= {24'h000000, opctl_q};
                ndc_pkg::OFS_IOCFG1: wb_dat_o <= {24'h000000, iocfg1_q};
                ndc_pkg::OFS_IOCFG2: wb_dat_o <= {24'h000000, iocfg2_q};
                ndc_pkg::OFS_CMD: wb_dat_o <= {24'h000000, last_cmd_q};
                ndc_pkg::OFS_AUX: wb_dat_o <= {24'h000000, aux_q};
                ndc_pkg::OFS_STATUS:
                    wb_dat_o <= {27'h0000000, test_wr_q, transp_q,
                                 refused_q, state_q};
                ndc_pkg::OFS_RESULT: wb_dat_o <= {24'h000000, result_q};
                ndc_pkg::OFS_GAIN: wb_dat_o <= {28'h0000000, gain_q};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    assign wb_ack_o = ack_q;

    // ----------------------------------------------------------------
    // Command issue
    // ----------------------------------------------------------------
    logic cmd_wr;
    logic [7:0] code;
    ndc_pkg::ndc_info_type info;
    logic accept;
    logic is_def;
    logic is_clr;

    assign code = wb_dat_i[7:0];
    assign cmd_wr = wr_lo && (wb_adr_i == ndc_pkg::OFS_CMD);
    assign info = info_of(code);
    // A running terminating command blocks all but chainable ones
    assign accept = cmd_wr && info.known &&
                    mode_ok(code, opctl_q, aux_q, xtal_stable_i) &&
                    (state_q == ndc_pkg::ST_IDLE || info.chain);
    assign is_def = accept && (code == ndc_pkg::CMD_SET_DEFAULT);
    assign is_clr = accept && (code == ndc_pkg::CMD_CLEAR_A ||
                               code == ndc_pkg::CMD_CLEAR_B);

    // ----------------------------------------------------------------
    // Registers kept across set default
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            opctl_q <= ndc_pkg::RST_OPCTL;
            iocfg1_q <= ndc_pkg::RST_IOCFG1;
            iocfg2_q <= ndc_pkg::RST_IOCFG2;
        end else if (ce_i && wr_lo) begin
            // Besides bus writes, only power-up reset touches these three
            if (wb_adr_i == ndc_pkg::OFS_OPCTL) begin
                opctl_q <= wb_dat_i[7:0];
            end
            if (wb_adr_i == ndc_pkg::OFS_IOCFG1) begin
                iocfg1_q <= wb_dat_i[7:0];
            end
            if (wb_adr_i == ndc_pkg::OFS_IOCFG2) begin
                iocfg2_q <= wb_dat_i[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers returned to default by set default
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aux_q <= ndc_pkg::RST_AUX;
        end else if (ce_i) begin
            if (is_def) begin
                aux_q <= ndc_pkg::RST_AUX;
            end else if (wr_lo && wb_adr_i == ndc_pkg::OFS_AUX) begin
                aux_q <= wb_dat_i[7:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_cmd_q <= ndc_pkg::RST_BYTE;
            refused_q <= 1'b0;
        end else if (ce_i && cmd_wr) begin
            if (is_def) begin
                last_cmd_q <= ndc_pkg::RST_BYTE;
                refused_q <= 1'b0;
            end else if (accept) begin
                last_cmd_q <= code;
                refused_q <= 1'b0;
            end else begin
                refused_q <= 1'b1;
            end
        end
    end

    // Measurement and calibration results
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_q <= ndc_pkg::RST_BYTE;
        end else if (ce_i) begin
            if (is_def) begin
                result_q <= ndc_pkg::RST_BYTE;
            end else if (state_q == ndc_pkg::ST_RUN && eng_done_i) begin
                result_q <= eng_result_i;
            end
        end
    end

    // Receiver gain reduction
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gain_q <= ndc_pkg::RST_GAIN;
        end else if (ce_i) begin
            if (is_def) begin
                gain_q <= ndc_pkg::RST_GAIN;
            end else if (accept && code == ndc_pkg::CMD_SQUELCH) begin
                gain_q <= noise_gain_i;
            end else if (accept && code == ndc_pkg::CMD_RESET_GAIN) begin
                gain_q <= aux_q[ndc_pkg::BIT_MGAIN_LO +: 4];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            transp_q <= 1'b0;
            test_wr_q <= 1'b0;
        end else if (ce_i) begin
            if (is_def) begin
                transp_q <= 1'b0;
                test_wr_q <= 1'b0;
            end else if (accept) begin
                if (code == ndc_pkg::CMD_TRANSPARENT) begin
                    transp_q <= 1'b1;
                end
                if (code == ndc_pkg::CMD_TEST_ACCESS) begin
                    test_wr_q <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Run state and termination interrupt
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ndc_pkg::ST_IDLE;
        end else if (ce_i) begin
            unique case (state_q)
                ndc_pkg::ST_IDLE: begin
                    if (accept && info.term_irq) begin
                        state_q <= ndc_pkg::ST_RUN;
                    end
                end
                ndc_pkg::ST_RUN: begin
                    // Clear aborts the engine without a termination irq
                    if (is_clr) begin
                        state_q <= ndc_pkg::ST_IDLE;
                    end else if (eng_done_i) begin
                        state_q <= ndc_pkg::ST_DONE;
                    end
                end
                ndc_pkg::ST_DONE: state_q <= ndc_pkg::ST_IDLE;
                default: state_q <= ndc_pkg::ST_IDLE;
            endcase
        end
    end

    assign term_irq_o = (state_q == ndc_pkg::ST_DONE);
    assign busy_o = (state_q != ndc_pkg::ST_IDLE);

    // ----------------------------------------------------------------
    // Action strobes
    // ----------------------------------------------------------------
    logic [ndc_pkg::NUM_ACT-1:0] act_q;

    for (genvar i = 0; i < ndc_pkg::NUM_ACT; i++) begin : g_act
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                act_q[i] <= 1'b0;
            end else if (ce_i) begin
                act_q[i] <= accept && info.act == 5'(i) &&
                    code != ndc_pkg::CMD_TEST_ACCESS;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clear_o <= '0;
        end else if (ce_i) begin
            clear_o.stop_rxtx <= is_clr;
            clear_o.stop_timers <= is_clr;
            clear_o.keep_nrt <= is_clr && aux_q[ndc_pkg::BIT_NRT_EMV];
            clear_o.clear_coll_irq <= is_clr || is_def;
            // Without en the FIFO survives set default
            clear_o.fifo_clear <= is_clr ||
                (is_def && opctl_q[ndc_pkg::BIT_EN]);
        end
    end

    assign act_o = act_q;
    assign transparent_o = transp_q;
    assign test_wr_en_o = test_wr_q;
    assign gain_red_o = gain_q;
    assign opctl_o = opctl_q;
    assign iocfg1_o = iocfg1_q;
    assign iocfg2_o = iocfg2_q;

endmodule : ndc_decoder

// ### hw/ndc_pkg.sv
// Package of constants and types for the direct-command decoder
package ndc_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_OPCTL = 8'h00;
    localparam logic [7:0] OFS_IOCFG1 = 8'h04;
    localparam logic [7:0] OFS_IOCFG2 = 8'h08;
    localparam logic [7:0] OFS_CMD = 8'h0C;
    localparam logic [7:0] OFS_AUX = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_RESULT = 8'h18;
    localparam logic [7:0] OFS_GAIN = 8'h1C;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int BIT_EN = 7;
    localparam int BIT_RX_EN = 6;
    localparam int BIT_TX_EN = 3;
    localparam int BIT_WU = 2;
    localparam int BIT_REG_S = 0;
    localparam int BIT_CS_MCAL = 1;
    localparam int BIT_NRT_EMV = 2;
    localparam int BIT_TGT_INIT = 3;
    localparam int BIT_MGAIN_LO = 4;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_OPCTL = 8'h00;
    localparam logic [7:0] RST_IOCFG1 = 8'h00;
    localparam logic [7:0] RST_IOCFG2 = 8'h00;
    localparam logic [7:0] RST_AUX = 8'h00;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_GAIN = 4'h0;

    // ----------------------------------------------------------------
    // Command codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_SET_DEFAULT = 8'hC1;
    localparam logic [7:0] CMD_CLEAR_A = 8'hC2;
    localparam logic [7:0] CMD_CLEAR_B = 8'hC3;
    localparam logic [7:0] CMD_UNMASK_RX = 8'hD1;
    localparam logic [7:0] CMD_MEAS_AMP = 8'hD3;
    localparam logic [7:0] CMD_SQUELCH = 8'hD4;
    localparam logic [7:0] CMD_RESET_GAIN = 8'hD5;
    localparam logic [7:0] CMD_ADJ_REG = 8'hD6;
    localparam logic [7:0] CMD_CAL_MOD = 8'hD7;
    localparam logic [7:0] CMD_CAL_ANT = 8'hD8;
    localparam logic [7:0] CMD_MEAS_PHASE = 8'hD9;
    localparam logic [7:0] CMD_CLR_SIGSTR = 8'hDA;
    localparam logic [7:0] CMD_TRANSPARENT = 8'hDC;
    localparam logic [7:0] CMD_CAL_CAP = 8'hDD;
    localparam logic [7:0] CMD_MEAS_CAP = 8'hDE;
    localparam logic [7:0] CMD_MEAS_SUPPLY = 8'hDF;
    localparam logic [7:0] CMD_START_GPT = 8'hE0;
    localparam logic [7:0] CMD_START_WUT = 8'hE1;
    localparam logic [7:0] CMD_START_MRT = 8'hE2;
    localparam logic [7:0] CMD_START_NRT = 8'hE3;
    localparam logic [7:0] CMD_TEST_ACCESS = 8'hFC;

    // ----------------------------------------------------------------
    // Action strobe indices
    // ----------------------------------------------------------------
    localparam int NUM_ACT = 19;
    localparam int A_UNMASK_RX = 0;
    localparam int A_MEAS_AMP = 1;
    localparam int A_SQUELCH = 2;
    localparam int A_RESET_GAIN = 3;
    localparam int A_ADJ_REG = 4;
    localparam int A_CAL_MOD = 5;
    localparam int A_CAL_ANT = 6;
    localparam int A_MEAS_PHASE = 7;
    localparam int A_CLR_SIGSTR = 8;
    localparam int A_TRANSPARENT = 9;
    localparam int A_CAL_CAP = 10;
    localparam int A_MEAS_CAP = 11;
    localparam int A_MEAS_SUPPLY = 12;
    localparam int A_START_GPT = 13;
    localparam int A_START_WUT = 14;
    localparam int A_START_MRT = 15;
    localparam int A_START_NRT = 16;
    localparam int A_SET_DEFAULT = 17;
    localparam int A_CLEAR = 18;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic known;
        logic chain;
        logic term_irq;
        logic [4:0] act;
    } ndc_info_type;

    typedef struct packed {
        logic stop_rxtx;
        logic fifo_clear;
        logic stop_timers;
        logic keep_nrt;
        logic clear_coll_irq;
    } ndc_clear_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_DONE = 2'b11
    } ndc_state_type;

endpackage : ndc_pkg

// ### test/ndc_engine_model.sv
// Analog engine stand-in that finishes terminating commands
`timescale 1ns/1ps
module ndc_engine_model #(
    parameter logic [7:0] RESULT = 8'hA5
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic slow_i,
    input wire logic [18:0] act_i,
    output logic eng_done_o,
    output logic [7:0] eng_result_o
);
    // Strobes of commands that end with an interrupt
    localparam logic [18:0] TERM_MASK = 19'h01CF2;
    logic run_q;
    logic [5:0] cnt_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_q <= 1'h0;
            cnt_q <= 6'h00;
            eng_done_o <= 1'h0;
        end else begin
            eng_done_o <= 1'h0;
            if (|(act_i & TERM_MASK)) begin
                run_q <= 1'h1;
                cnt_q <= slow_i ? 6'h28 : 6'h02;
            end else if (run_q && cnt_q == 6'h00) begin
                run_q <= 1'h0;
                eng_done_o <= 1'h1;
            end else if (run_q) begin
                cnt_q <= cnt_q - 6'h01;
            end
        end
    end
    // Inverted outside the pulse so a capture at the wrong time shows
    assign eng_result_o = eng_done_o ? RESULT : ~RESULT;
endmodule : ndc_engine_model

// ### test/ndc_decoder_assertions.sv
// Port checker for the direct-command decoder
`timescale 1ns/1ps
module ndc_decoder_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic xtal_stable_i,
    input wire logic eng_done_i,
    input wire logic [18:0] act_o,
    input wire ndc_pkg::ndc_clear_type clear_o,
    input wire logic term_irq_o,
    input wire logic busy_o,
    input wire logic [7:0] opctl_o
);
    logic wr, en;
    logic [7:0] cd;
    assign cd = wb_dat_i[7:0];
    assign en = opctl_o[ndc_pkg::BIT_EN];
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && ce_i
        && wb_sel_i[0] && wb_adr_i == ndc_pkg::OFS_CMD;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i
        |=> wb_ack_o ##1 !wb_ack_o) else $error("ack timing");
    a_irq_cause: assert property (term_irq_o |-> $past(eng_done_i)
        && busy_o) else $error("irq without done");
    a_mode_refuse: assert property (wr && cd == 8'hD3 && !en
        |=> act_o == '0) else $error("command taken without en");
    a_meas_accept: assert property (wr && cd == 8'hD3 && en
        && !busy_o |=> act_o[1] && busy_o) else $error("amplitude lost");
    a_busy_refuse: assert property (wr && cd == 8'hD9 && busy_o
        |=> !act_o[7]) else $error("phase chained");
    a_unmask_chain: assert property (wr && cd == 8'hD1 && en
        && opctl_o[6] |=> act_o[0]) else $error("unmask lost");
    a_clear_accept: assert property (wr && cd == 8'hC2 |=> act_o[18]
        == ($past(en) && $past(xtal_stable_i)))
        else $error("clear acceptance");
    a_setdef_keep: assert property (wr && cd == 8'hC1 && !busy_o
        |=> act_o[17] && clear_o.fifo_clear == $past(en)
        && $stable(opctl_o)) else $error("set default effect");
    a_unused_code: assert property (wr && (cd == 8'hD2 || cd == 8'hFC)
        |=> act_o == '0 && clear_o == '0) else $error("stray strobe");
endmodule : ndc_decoder_checker

// ### test/ndc_tb.sv
// Self-checking bench for the direct-command decoder
`timescale 1ns/1ps
module tb;
    localparam logic [7:0] RES = 8'hA5;
    localparam logic [18:0] TERM = 19'h01CF2;
    localparam logic [7:0] CODES [22] = '{8'hD1, 8'hD3, 8'hD4, 8'hD5,
        8'hD6, 8'hD7, 8'hD8, 8'hD9, 8'hDA, 8'hDC, 8'hDD, 8'hDE, 8'hDF,
        8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hC1, 8'hC2, 8'hC3, 8'hFC, 8'hD2};
    localparam logic [7:0] CH[6] = '{8'hD3, 8'hD1, 8'hD9, 8'hDA, 8'hC2, 8'hC3};
    localparam logic [18:0] CH_ACT [6] = '{19'h00002, 19'h00001, 19'h00000,
        19'h00100, 19'h00000, 19'h40000};
    logic clk_i = 1'h0, rst_i = 1'h1, ce_i = 1'h1, wb_we_i = 1'h0;
    logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, xtal_stable_i = 1'h1, slow_q = '0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, rd, wb_dat_o;
    logic [3:0] wb_sel_i = 4'h0, noise_gain_i = 4'h0;
    logic eng_done_i, wb_ack_o, term_irq_o, busy_o, tr_o, tw_o;
    logic [7:0] eng_result_i, opctl_o;
    logic [18:0] act_o, act_s;
    ndc_pkg::ndc_clear_type clear_o, clr_s;
    int mismatches = 0, cmp_count = 0, irq_n = 0, irq_exp = 0, cycles = 0;
    int seed = 19;
    always #50 clk_i = ~clk_i;
    ndc_decoder i_dut (.clk_i, .rst_i, .ce_i, .wb_adr_i, .wb_dat_i,
        .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o,
        .xtal_stable_i, .eng_done_i, .eng_result_i, .noise_gain_i, .act_o,
        .clear_o, .term_irq_o, .busy_o, .transparent_o(tr_o), .opctl_o,
        .test_wr_en_o(tw_o), .gain_red_o(), .iocfg1_o(), .iocfg2_o());
    ndc_engine_model #(.RESULT(RES)) i_eng (.clk_i, .rst_i, .slow_i(slow_q),
        .act_i(act_o), .eng_done_o(eng_done_i), .eng_result_o(eng_result_i));
    // Acceptance as the command table defines it
    function automatic bit accept_of(input logic [7:0] c, op, ax, input bit x);
        case (c)
            8'hC1, 8'hDE, 8'hFC: return 1;
            8'hC2, 8'hC3: return op[7] && x;
            8'hD1, 8'hD4, 8'hE3: return op[7] && op[6];
            8'hD6: return op[7] && !ax[0];
            8'hDD: return !ax[1];
            8'hE1: return !op[2];
            8'hE2: return ax[3];
            8'hD3, 8'hD5, 8'hD7, 8'hD8, 8'hD9, 8'hDA, 8'hDC, 8'hDF,
            8'hE0: return op[7];
            default: return 0;
        endcase
    endfunction : accept_of
    task automatic check(input string what, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic bus(input logic we, input logic [7:0] adr, dat);
        int n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= {24'h0, dat};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 50);
        if (n == 50) mismatches++;
        rd = wb_dat_o;
        act_s = act_o;
        clr_s = clear_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
    endtask : bus
    task automatic wait_idle();
        int n;
        for (n = 0; busy_o !== 1'h0 && n < 100; n++) @(posedge clk_i);
        if (n == 100) mismatches++;
    endtask : wait_idle
    task automatic wrap_up();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up
    always @(posedge clk_i) begin
        cycles++;
        if (term_irq_o === 1'h1) irq_n++;
        if (cycles == 20000) begin
            mismatches++;
            wrap_up();
        end
    end
    initial begin
        int i, k;
        logic [7:0] op, ax;
        bit ok, tr_m, tw_m;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'h0;
        bus(1'h0, 8'h40, 8'h00);
        check("unmapped", rd, 32'h0);
        for (int r = 0; r < 66; r++) begin
            i = r % 22;
            k = (i == 19) ? 18 : i;
            op = 8'($random(seed));
            ax = 8'($random(seed)) & 8'h0F;
            xtal_stable_i <= 1'($random(seed));
            slow_q <= 1'($random(seed));
            noise_gain_i <= 4'($random(seed));
            bus(1'h1, ndc_pkg::OFS_OPCTL, op);
            bus(1'h1, ndc_pkg::OFS_AUX, ax);
            ok = accept_of(CODES[i], op, ax, xtal_stable_i) && i < 20;
            bus(1'h1, ndc_pkg::OFS_CMD, CODES[i]);
            check("act", 32'(act_s), ok ? 32'h1 << k : 32'h0);
            if (ok && TERM[k]) irq_exp++;
            wait_idle();
            check("irq", 32'(irq_n), 32'(irq_exp));
            if (ok && i == 9) tr_m = 1'h1;
            if (i == 20) tw_m = 1'h1;
            if (ok && i == 17) {tr_m, tw_m} = 2'h0;
            check("lvl", 32'({tr_o, tw_o}), 32'({tr_m, tw_m}));
            if (ok && i == 1) bus(1'h0, ndc_pkg::OFS_RESULT, 8'h00);
            if (ok && i == 1) check("result", rd, 32'(RES));
            if (ok && i == 2) bus(1'h0, ndc_pkg::OFS_GAIN, 8'h00);
            if (ok && i == 2) check("gain", rd, 32'(noise_gain_i));
            if (i == 17) begin
                check("fifo", 32'(clr_s.fifo_clear), 32'(op[7]));
                bus(1'h0, ndc_pkg::OFS_OPCTL, 8'h00);
                check("opctl", rd, 32'(op));
                bus(1'h0, ndc_pkg::OFS_AUX, 8'h00);
                check("aux", rd, 32'(ndc_pkg::RST_AUX));
            end
        end
        // Chained and refused codes while a slow measurement runs
        slow_q <= 1'h1;
        bus(1'h1, ndc_pkg::OFS_OPCTL, 8'hC0);
        bus(1'h1, ndc_pkg::OFS_AUX, 8'h04);
        for (int j = 0; j < 6; j++) begin
            xtal_stable_i <= (j != 4);
            bus(1'h1, ndc_pkg::OFS_CMD, CH[j]);
            check("chain", 32'(act_s), 32'(CH_ACT[j]));
        end
        check("clear", 32'(clr_s), 32'h1F);
        repeat (60) @(posedge clk_i);
        check("abort", 32'(irq_n), 32'(irq_exp));
        wrap_up();
    end
endmodule : tb
bind ndc_decoder ndc_decoder_checker i_chk (.clk_i, .rst_i, .ce_i, .wb_adr_i,
    .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .xtal_stable_i, .eng_done_i, .act_o, .clear_o, .term_irq_o, .busy_o,
    .opctl_o);
